// ==== rtl/dtc_pkg.sv ====
// Package for the dual timer/counter: register map, field positions, modes
package dtc_pkg;

	// =====================================================
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
	localparam logic [7:0] ADDR_TIMER0_COUNT_LOW = 8'h8A;
	localparam logic [7:0] ADDR_TIMER1_COUNT_LOW = 8'h8B;
	localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH = 8'h8C;
	localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH = 8'h8D;

	// =====================================================
	// Control register bit positions
	localparam int CTL_T1_OVF = 7;
	localparam int CTL_T1_RUN = 6;
	localparam int CTL_T0_OVF = 5;
	localparam int CTL_T0_RUN = 4;
	localparam int CTL_IRQ1_EDGE = 3;
	localparam int CTL_IRQ1_TYPE = 2;
	localparam int CTL_IRQ0_EDGE = 1;
	localparam int CTL_IRQ0_TYPE = 0;

	// =====================================================
	// Mode register field positions
	localparam int MOD_T1_GATE = 7;
	localparam int MOD_T1_SRC = 6;
	localparam int MOD_T1_MODE_HI = 5;
	localparam int MOD_T1_MODE_LO = 4;
	localparam int MOD_T0_GATE = 3;
	localparam int MOD_T0_SRC = 2;
	localparam int MOD_T0_MODE_HI = 1;
	localparam int MOD_T0_MODE_LO = 0;

	// =====================================================
	// Reset values and timing
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int TICK_DIV = 12;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);

	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'h0,
		DTC_MODE_16BIT = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT = 2'h3
	} dtc_mode_t;

	// Register bus request from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtc_sfr_req_t;

	// Per-timer control derived from the mode and control registers
	typedef struct packed {
		logic gate;
		logic src;
		dtc_mode_t mode;
		logic run;
	} dtc_tcfg_t;

endpackage

// ==== rtl/dtc_timer_counter.sv ====
// Two 16-bit timer/counters with external interrupt edge and level control
`timescale 1ns/1ps
module dtc_timer_counter (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire dtc_pkg::dtc_sfr_req_t SFR_REQ,
	output logic [7:0] SFR_RDATA,
	output logic SFR_HIT,
	input wire logic TIMER0_EVENT_PIN,
	input wire logic TIMER1_EVENT_PIN,
	input wire logic EXT_IRQ0_PIN,
	input wire logic EXT_IRQ1_PIN,
	input wire logic TIMER0_IRQ_ACK,
	input wire logic TIMER1_IRQ_ACK,
	input wire logic EXT_IRQ0_ACK,
	input wire logic EXT_IRQ1_ACK,
	output logic TIMER0_IRQ,
	output logic TIMER1_IRQ,
	output logic EXT_IRQ0_REQ,
	output logic EXT_IRQ1_REQ,
	output logic SERIAL_PORT0_BAUD_TICK
);
	import dtc_pkg::*;

	// =====================================================
	// Registers
	logic [7:0] timer_control_q;
	logic [7:0] timer_mode_config_q;
	logic [7:0] count_low_q [2];
	logic [7:0] count_high_q [2];
	logic [3:0] tick_cnt_q;
	logic tick;
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic [3:0] pin_prev_q;
	logic [3:0] pin_fall;
	logic [1:0] low_inc;
	logic [1:0] high_inc;
	logic [1:0] ovf;
	logic [1:0] wr_low;
	logic [1:0] wr_high;
	logic wr_ctl;
	logic wr_mod;
	logic [7:0] ctl_d;
	dtc_tcfg_t cfg [2];

	assign wr_ctl = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER_CONTROL);
	assign wr_mod = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER_MODE_CONFIG);
	assign wr_low[0] = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER0_COUNT_LOW);
	assign wr_low[1] = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER1_COUNT_LOW);
	assign wr_high[0] = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER0_COUNT_HIGH);
	assign wr_high[1] = SFR_REQ.wr && (SFR_REQ.addr == ADDR_TIMER1_COUNT_HIGH);

	// =====================================================
	// Prescaler: one tick every twelve clocks
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			tick_cnt_q <= 4'h0;
		end else if (tick_cnt_q == TICK_LAST) begin
			tick_cnt_q <= 4'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 4'h1;
		end
	end
	assign tick = (tick_cnt_q == TICK_LAST);

	// =====================================================
	// Pin synchronisers: bit0/1 event pins, bit2/3 irq pins
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			pin_meta_q <= 4'hF;
			pin_sync_q <= 4'hF;
			pin_prev_q <= 4'hF;
		end else begin
			pin_meta_q <= {EXT_IRQ1_PIN, EXT_IRQ0_PIN, TIMER1_EVENT_PIN, TIMER0_EVENT_PIN};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end
	assign pin_fall = pin_prev_q & ~pin_sync_q;

	// =====================================================
	// Per-timer configuration and counting
	assign cfg[0] = '{gate: timer_mode_config_q[MOD_T0_GATE],
		src: timer_mode_config_q[MOD_T0_SRC],
		mode: dtc_mode_t'(timer_mode_config_q[MOD_T0_MODE_HI:MOD_T0_MODE_LO]),
		run: timer_control_q[CTL_T0_RUN]};
	assign cfg[1] = '{gate: timer_mode_config_q[MOD_T1_GATE],
		src: timer_mode_config_q[MOD_T1_SRC],
		mode: dtc_mode_t'(timer_mode_config_q[MOD_T1_MODE_HI:MOD_T1_MODE_LO]),
		run: timer_control_q[CTL_T1_RUN]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tmr
			logic enable;
			logic event_in;
			logic low_full;
			logic [7:0] low_d;
			logic [7:0] high_d;
			logic hi_ovf;
			// Gate: run bit and, when gated, the matching irq pin high
			assign enable = cfg[gi].run && (!cfg[gi].gate || pin_sync_q[2 + gi]);
			assign event_in = cfg[gi].src ? pin_fall[gi] : tick;
			assign low_inc[gi] = enable && event_in && !(gi == 1 && cfg[1].mode == DTC_MODE_SPLIT);
			assign low_full = (cfg[gi].mode == DTC_MODE_13BIT) ? (count_low_q[gi][4:0] == 5'h1F)
				: (count_low_q[gi] == 8'hFF);

			always_comb begin
				low_d = count_low_q[gi];
				high_d = count_high_q[gi];
				hi_ovf = 1'b0;
				if (low_inc[gi]) begin
					unique case (cfg[gi].mode)
						DTC_MODE_13BIT: begin
							low_d = {3'h0, count_low_q[gi][4:0] + 5'h01};
							if (low_full) begin
								high_d = count_high_q[gi] + 8'h01;
								hi_ovf = (count_high_q[gi] == 8'hFF);
							end
						end
						DTC_MODE_16BIT: begin
							low_d = count_low_q[gi] + 8'h01;
							if (low_full) begin
								high_d = count_high_q[gi] + 8'h01;
								hi_ovf = (count_high_q[gi] == 8'hFF);
							end
						end
						DTC_MODE_RELOAD: begin
							low_d = low_full ? count_high_q[gi] : count_low_q[gi] + 8'h01;
							hi_ovf = low_full;
						end
						DTC_MODE_SPLIT: begin
							low_d = count_low_q[gi] + 8'h01;
							hi_ovf = low_full;
						end
					endcase
				end
				// Split mode: timer 0 high byte runs on tick under timer 1 run bit
				if (gi == 0 && high_inc[0]) begin
					high_d = count_high_q[0] + 8'h01;
				end
			end

			always_ff @(posedge REF_CLK) begin
				if (!RST_B) begin
					count_low_q[gi] <= RST_BYTE;
					count_high_q[gi] <= RST_BYTE;
				end else begin
					count_low_q[gi] <= wr_low[gi] ? SFR_REQ.wdata : low_d;
					count_high_q[gi] <= wr_high[gi] ? SFR_REQ.wdata : high_d;
				end
			end
			assign ovf[gi] = hi_ovf;
		end
	endgenerate

	// Timer 0 split high byte: clock ticks, started by timer 1 run bit
	assign high_inc[0] = (cfg[0].mode == DTC_MODE_SPLIT) && cfg[1].run && tick;
	assign high_inc[1] = 1'b0;

	// Overflow sources; in split mode the timer 1 flag comes from timer 0 high byte
	logic t0_ovf_evt;
	logic t1_ovf_evt;
	assign t0_ovf_evt = ovf[0];
	assign t1_ovf_evt = (cfg[0].mode == DTC_MODE_SPLIT)
		? (high_inc[0] && count_high_q[0] == 8'hFF) : ovf[1];

	// =====================================================
	// Control register: software write, acks clear, hardware set wins
	logic irq0_set;
	logic irq1_set;
	assign irq0_set = pin_fall[2];
	assign irq1_set = pin_fall[3];

	always_comb begin
		ctl_d = timer_control_q;
		if (wr_ctl) begin
			ctl_d = SFR_REQ.wdata;
		end
		if (TIMER0_IRQ_ACK) begin
			ctl_d[CTL_T0_OVF] = 1'b0;
		end
		if (TIMER1_IRQ_ACK) begin
			ctl_d[CTL_T1_OVF] = 1'b0;
		end
		if (EXT_IRQ0_ACK) begin
			ctl_d[CTL_IRQ0_EDGE] = 1'b0;
		end
		if (EXT_IRQ1_ACK) begin
			ctl_d[CTL_IRQ1_EDGE] = 1'b0;
		end
		if (t0_ovf_evt) begin
			ctl_d[CTL_T0_OVF] = 1'b1;
		end
		if (t1_ovf_evt) begin
			ctl_d[CTL_T1_OVF] = 1'b1;
		end
		if (irq0_set) begin
			ctl_d[CTL_IRQ0_EDGE] = 1'b1;
		end
		if (irq1_set) begin
			ctl_d[CTL_IRQ1_EDGE] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			timer_control_q <= RST_BYTE;
		end else begin
			timer_control_q <= ctl_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			timer_mode_config_q <= RST_BYTE;
		end else if (wr_mod) begin
			timer_mode_config_q <= SFR_REQ.wdata;
		end
	end

	// =====================================================
	// Interrupt requests and baud source
	assign TIMER0_IRQ = timer_control_q[CTL_T0_OVF];
	assign TIMER1_IRQ = timer_control_q[CTL_T1_OVF];
	assign EXT_IRQ0_REQ = timer_control_q[CTL_IRQ0_TYPE]
		? timer_control_q[CTL_IRQ0_EDGE] : !pin_sync_q[2];
	assign EXT_IRQ1_REQ = timer_control_q[CTL_IRQ1_TYPE]
		? timer_control_q[CTL_IRQ1_EDGE] : !pin_sync_q[3];

	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			SERIAL_PORT0_BAUD_TICK <= 1'b0;
		end else begin
			SERIAL_PORT0_BAUD_TICK <= ovf[1];
		end
	end

	// =====================================================
	// Register read: data registered one cycle after the read strobe
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			SFR_RDATA <= RST_BYTE;
			SFR_HIT <= 1'b0;
		end else begin
			SFR_HIT <= 1'b0;
			SFR_RDATA <= RST_BYTE;
			if (SFR_REQ.rd) begin
				SFR_HIT <= 1'b1;
				unique case (SFR_REQ.addr)
					ADDR_TIMER_CONTROL: SFR_RDATA <= timer_control_q;
					ADDR_TIMER_MODE_CONFIG: SFR_RDATA <= timer_mode_config_q;
					ADDR_TIMER0_COUNT_LOW: SFR_RDATA <= count_low_q[0];
					ADDR_TIMER1_COUNT_LOW: SFR_RDATA <= count_low_q[1];
					ADDR_TIMER0_COUNT_HIGH: SFR_RDATA <= count_high_q[0];
					ADDR_TIMER1_COUNT_HIGH: SFR_RDATA <= count_high_q[1];
					default: SFR_HIT <= 1'b0;
				endcase
			end
		end
	end

endmodule

// ==== tb/dtc_core_model.sv ====
// Core-side model that services pending interrupt requests
`timescale 1ns/1ps
module dtc_core_model (
	input wire logic clk,
	input wire logic ack_en,
	input wire logic [3:0] req,
	output logic [3:0] ack
);
	logic [3:0] ack_q = 4'h0;
	assign ack = ack_q;
	// =====
	// One-cycle service pulse, then a gap before the next
	always_ff @(posedge clk) begin
		ack_q <= {4{ack_en}} & req & ~ack_q;
	end
endmodule

// ==== tb/dtc_timer_counter_props.sv ====
// Port checker for the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_counter_props (
	input wire logic REF_CLK,
	input wire logic RST_B,
	input wire dtc_pkg::dtc_sfr_req_t SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	input wire logic SFR_HIT,
	input wire logic EXT_IRQ0_PIN,
	input wire logic EXT_IRQ1_PIN,
	input wire logic TIMER0_IRQ_ACK,
	input wire logic TIMER1_IRQ_ACK,
	input wire logic TIMER0_IRQ,
	input wire logic TIMER1_IRQ,
	input wire logic EXT_IRQ0_REQ,
	input wire logic EXT_IRQ1_REQ,
	input wire logic SERIAL_PORT0_BAUD_TICK
);
	import dtc_pkg::*;
	logic typ0_q;
	logic typ1_q;
	logic map;
	logic ctl_wr;
	assign map = SFR_REQ.addr inside {[8'h88:8'h8D]};
	assign ctl_wr = SFR_REQ.wr && SFR_REQ.addr == ADDR_TIMER_CONTROL;
	// =====
	// Mirror of the software-only type bits
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			typ0_q <= 1'b0;
			typ1_q <= 1'b0;
		end else if (ctl_wr) begin
			typ0_q <= SFR_REQ.wdata[CTL_IRQ0_TYPE];
			typ1_q <= SFR_REQ.wdata[CTL_IRQ1_TYPE];
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	a_read_hit: assert property (SFR_REQ.rd && map |=> SFR_HIT)
		else $error("no hit");
	a_miss_quiet: assert property (!(SFR_REQ.rd && map) |=> !SFR_HIT)
		else $error("stray hit");
	a_idle_data: assert property (!SFR_REQ.rd |=> SFR_RDATA == 8'h00)
		else $error("stray data");
	a_t0_flag_hold: assert property (TIMER0_IRQ && !TIMER0_IRQ_ACK && !ctl_wr |=> TIMER0_IRQ)
		else $error("t0 flag lost");
	a_t1_flag_hold: assert property (TIMER1_IRQ && !TIMER1_IRQ_ACK && !ctl_wr |=> TIMER1_IRQ)
		else $error("t1 flag lost");
	a_irq0_level: assert property ((!typ0_q && !EXT_IRQ0_PIN)[*3] |-> EXT_IRQ0_REQ)
		else $error("irq0 level");
	a_irq1_idle: assert property ((!typ1_q && EXT_IRQ1_PIN)[*3] |-> !EXT_IRQ1_REQ)
		else $error("irq1 idle");
	a_irq1_edge: assert property (typ1_q && $fell(EXT_IRQ1_PIN) |-> ##[1:4] EXT_IRQ1_REQ)
		else $error("irq1 edge");
	a_baud_pulse: assert property (SERIAL_PORT0_BAUD_TICK |=> !SERIAL_PORT0_BAUD_TICK)
		else $error("baud pulse");
	c_t0_ovf: cover property ($rose(TIMER0_IRQ));
	c_t1_ovf: cover property ($rose(TIMER1_IRQ));
	c_baud: cover property (SERIAL_PORT0_BAUD_TICK);
endmodule
bind dtc_timer_counter dtc_timer_counter_props dtc_timer_counter_props_i (
	.REF_CLK(REF_CLK), .RST_B(RST_B), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
	.SFR_HIT(SFR_HIT), .EXT_IRQ0_PIN(EXT_IRQ0_PIN), .EXT_IRQ1_PIN(EXT_IRQ1_PIN),
	.TIMER0_IRQ_ACK(TIMER0_IRQ_ACK), .TIMER1_IRQ_ACK(TIMER1_IRQ_ACK),
	.TIMER0_IRQ(TIMER0_IRQ), .TIMER1_IRQ(TIMER1_IRQ), .EXT_IRQ0_REQ(EXT_IRQ0_REQ),
	.EXT_IRQ1_REQ(EXT_IRQ1_REQ), .SERIAL_PORT0_BAUD_TICK(SERIAL_PORT0_BAUD_TICK));

// ==== tb/dtc_timer_counter_test.sv ====
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_counter_test;
	import dtc_pkg::*;
	logic clk = 0;
	logic rst_b = 0;
	dtc_sfr_req_t req = '0;
	logic [7:0] rdata;
	logic hit, baud;
	logic ack_en = 0;
	logic ev0 = 1;
	logic ev1 = 1;
	logic p0 = 1;
	logic p1 = 1;
	logic [3:0] irq, ack;
	logic [7:0] ra [5] = '{8'h8A, 8'h8C, 8'h8B, 8'h8D, 8'h89};
	logic [7:0] rv [5] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h96};
	int n_fail = 0;
	int compares = 0;
	int ticks = 0;
	dtc_timer_counter dtc_timer_counter_i (.REF_CLK(clk), .RST_B(rst_b), .SFR_REQ(req),
		.SFR_RDATA(rdata), .SFR_HIT(hit), .TIMER0_EVENT_PIN(ev0), .TIMER1_EVENT_PIN(ev1),
		.EXT_IRQ0_PIN(p0), .EXT_IRQ1_PIN(p1), .TIMER0_IRQ_ACK(ack[0]),
		.TIMER1_IRQ_ACK(ack[1]), .EXT_IRQ0_ACK(ack[2]), .EXT_IRQ1_ACK(ack[3]),
		.TIMER0_IRQ(irq[0]), .TIMER1_IRQ(irq[1]), .EXT_IRQ0_REQ(irq[2]),
		.EXT_IRQ1_REQ(irq[3]), .SERIAL_PORT0_BAUD_TICK(baud));
	dtc_core_model dtc_core_model_i (.clk(clk), .ack_en(ack_en), .req(irq), .ack(ack));
	always #25 clk = ~clk;
	always @(posedge clk) ticks += (baud === 1'b1);
	task automatic wrap_up();
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #2;
		req = '{1'b1, 1'b0, a, d};
		@(posedge clk) #2;
		req = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) #2;
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) #2;
		req = '0;
		chk(rdata, exp);
		chk({7'h00, hit}, {7'h00, a >= 8'h88 && a <= 8'h8D});
	endtask
	task automatic pulse(input int n, input logic sel);
		repeat (n) begin
			@(posedge clk) #2;
			if (sel)
				ev1 = 0;
			else
				ev0 = 0;
			repeat (3) @(posedge clk);
			#2 {ev1, ev0} = 2'b11;
			repeat (3) @(posedge clk);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#2 rst_b = 1;
		for (int i = 0; i < 6; i++) rd(8'h88 + 8'(i), 8'h00);
		rd(8'h90, 8'h00);
		foreach (ra[i]) wr(ra[i], rv[i]);
		foreach (ra[i]) rd(ra[i], rv[i]);
		// Timer 0, 13-bit mode, wraps on the first tick
		wr(8'h89, 8'h00);
		wr(8'h8A, 8'hFF);
		wr(8'h8C, 8'hFF);
		wr(8'h88, 8'h10);
		for (int k = 0; irq[0] !== 1'b1; k++) begin
			if (k == 100) begin
				chk(8'h00, 8'h01);
				wrap_up();
			end
			@(posedge clk) #2;
		end
		repeat (64) @(posedge clk);
		rd(8'h8A, 8'h05);
		rd(8'h8C, 8'h00);
		rd(8'h88, 8'h30);
		wr(8'h88, 8'h00);
		rd(8'h88, 8'h00);
		// Timer 1 counts pin events with reload
		wr(8'h89, 8'h60);
		wr(8'h8B, 8'hFE);
		wr(8'h8D, 8'hFE);
		wr(8'h88, 8'h40);
		pulse(2, 1'b1);
		rd(8'h8B, 8'hFE);
		rd(8'h88, 8'hC0);
		chk(8'(ticks), 8'h01);
		// Timer 1 gated by its interrupt pin
		wr(8'h89, 8'hD0);
		wr(8'h8B, 8'h00);
		wr(8'h88, 8'h44);
		@(posedge clk) #2 {p0, p1} = 2'b00;
		pulse(2, 1'b1);
		rd(8'h8B, 8'h00);
		@(posedge clk) #2 p1 = 1;
		pulse(2, 1'b1);
		rd(8'h8B, 8'h02);
		rd(8'h88, 8'h4E);
		@(posedge clk) #2 ack_en = 1;
		repeat (4) @(posedge clk);
		rd(8'h88, 8'h44);
		chk({7'h00, irq[2]}, 8'h01);
		// Timer 0 counts its own pin in 16-bit mode, gated by irq0 pin
		@(posedge clk) #2 ack_en = 0;
		wr(8'h89, 8'h0D);
		wr(8'h8A, 8'hFF);
		wr(8'h8C, 8'hFF);
		wr(8'h88, 8'h10);
		pulse(1, 1'b0);
		rd(8'h8A, 8'hFF);
		@(posedge clk) #2 p0 = 1;
		pulse(1, 1'b0);
		rd(8'h8A, 8'h00);
		rd(8'h8C, 8'h00);
		rd(8'h88, 8'h30);
		wrap_up();
	end
endmodule
